// file: logic/prm_top.sv
// Purpose: power and clock manager start-up, clock select, sleep, interrupt
// Assumes: pclk runs at 50 MHz, not from the 115 kHz rc oscillator, apb with zero wait states
// Notes: clock enables drive gating cells outside; dividers live outside too
//
// Implementation choices: the register offsets and the APB slave port.
module prm_top
    import prm_pkg::*;
#(
    parameter int NPB = 2,
    parameter int NMOD = 32,
    parameter int NSRC = 4
)
(
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input logic reset_pin_n,
    input logic io_supply_monitor_ok,
    input logic core_supply_monitor_ok,
    input logic fuse_io_mon_keep,
    input logic fuse_core_mon_keep,
    input logic wdt_reset_req,
    input logic [NSRC-1:0] src_ready,
    input logic sleep_req,
    input logic [2:0] sleep_mode,
    input logic wake_irq,
    output logic sys_rst_n_q,
    output logic io_mon_en_q,
    output logic core_mon_en_q,
    output logic rc_osc_en_q,
    output logic osc_en_q,
    output logic [1:0] pll_en_q,
    output logic [MCW-1:0] main_clk_sel_q,
    output logic [7:0] cpu_div_q,
    output logic [NPB-1:0][7:0] pb_div_q,
    output logic cpu_clk_en_q,
    output logic hsb_clk_en_q,
    output logic [NPB-1:0] pb_clk_en_q,
    output logic [NMOD-1:0] mod_clk_en_q,
    output logic mgr_clk_en_q,
    output logic usb_reg_en_q,
    output logic cpu_fetch_en_q,
    output logic [31:0] boot_addr_q,
    output logic irq_q
);
    logic srst_n;
    logic loaded_q;
    logic setup;
    logic wr_en;
    logic rd_done;
    logic hit;
    logic [31:0] rd_v;
    logic ckrdy;
    logic ck_rise;
    logic wr_clk;
    logic [NPB-1:0] pb_wr;
    logic [CK_CNT_W-1:0] ck_cnt_q;
    logic soft_q;
    logic [NIRQ-1:0] isr_q;
    logic [NIRQ-1:0] imr_q;
    logic [NIRQ-1:0] ev;
    prm_slp_e slp_q;
    prm_slp_e slp_d;
    logic [2:0] slp_mode_q;
    logic [2:0] mode_d;

    prm_rst_if rif();

    prm_rst_ctl u_rst (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif.ctl)
    );

    assign rif.io_ok = io_supply_monitor_ok;
    assign rif.core_ok = core_supply_monitor_ok;
    assign rif.io_en = io_mon_en_q;
    assign rif.core_en = core_mon_en_q;
    assign rif.pin_n = reset_pin_n;
    assign rif.soft_req = soft_q;
    assign rif.wdt_req = wdt_reset_req;
    assign srst_n = rif.sys_rst_n;
    assign sys_rst_n_q = rif.sys_rst_n;

    // ******************************
    // supply monitor enables
    // ******************************
    // fuses are read once after the first release, never again
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            io_mon_en_q <= 1'b1;
            core_mon_en_q <= 1'b1;
            loaded_q <= 1'b0;
        end
        else if (srst_n && !loaded_q)
        begin
            io_mon_en_q <= fuse_io_mon_keep;
            core_mon_en_q <= fuse_core_mon_keep;
            loaded_q <= 1'b1;
        end
    end

    // ******************************
    // apb slave
    // ******************************
    assign setup = psel && !penable;
    // a stopped bus clock means the registers no longer take writes
    assign wr_en = psel && penable && pready_q && pwrite && mgr_clk_en_q;
    assign rd_done = psel && penable && pready_q && !pwrite;

    always_comb
    begin
        rd_v = 32'h0;
        hit = 1'b1;
        case (paddr)
            OFS_MAIN_CLOCK_SOURCE_SELECT: rd_v = {{(32-MCW){1'b0}}, main_clk_sel_q};
            OFS_PROCESSOR_CLOCK_SELECT, OFS_FAST_BUS_CLOCK_SELECT: rd_v = {24'h0, cpu_div_q};
            OFS_CLKMASK: rd_v = 32'(mod_clk_en_q);
            OFS_CTRL: rd_v = {27'h0, usb_reg_en_q, soft_q, !mgr_clk_en_q, pll_en_q};
            OFS_SLEEP: rd_v = {29'h0, slp_mode_q};
            OFS_RCAUSE: rd_v = {{(32-NCAUSE){1'b0}}, rif.cause};
            OFS_ISR: rd_v = {{(32-NIRQ){1'b0}}, isr_q};
            OFS_IMR: rd_v = {{(32-NIRQ){1'b0}}, imr_q};
            OFS_SR: rd_v = {28'h0, core_mon_en_q, io_mon_en_q, slp_q, ckrdy};
            default:
            begin
                hit = 1'b0;
                for (int i = 0; i < NPB; i++)
                begin
                    if (paddr == OFS_PBSEL0 + 8'(4 * i))
                    begin
                        hit = 1'b1;
                        rd_v = {24'h0, pb_div_q[i]};
                    end
                end
            end
        endcase
        if (!mgr_clk_en_q)
            rd_v = 32'h0;
    end

    always_ff @(posedge pclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup;
            if (setup)
            begin
                prdata_q <= pwrite ? 32'h0 : rd_v;
                pslverr_q <= !hit;
            end
        end
    end

    // ******************************
    // main clock and dividers
    // ******************************
    always_ff @(posedge pclk or negedge srst_n)
    begin
        if (!srst_n)
            main_clk_sel_q <= MC_RC;
        else if (wr_en && paddr == OFS_MAIN_CLOCK_SOURCE_SELECT && src_ready[pwdata[MCW-1:0]])
            main_clk_sel_q <= pwdata[MCW-1:0];
    end

    // writes during a pending change are dropped, they could hang the clocks
    assign wr_clk = wr_en && ckrdy && (paddr == OFS_PROCESSOR_CLOCK_SELECT || (|pb_wr));
    assign ckrdy = ck_cnt_q == '0;
    assign ck_rise = ck_cnt_q == CK_CNT_W'(1);

    always_ff @(posedge pclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            cpu_div_q <= DIV_RST;
            ck_cnt_q <= '0;
        end
        else
        begin
            if (wr_en && ckrdy && paddr == OFS_PROCESSOR_CLOCK_SELECT)
                cpu_div_q <= pwdata[7:0];
            if (wr_clk)
                ck_cnt_q <= CK_LOAD;
            else if (!ckrdy)
                ck_cnt_q <= ck_cnt_q - CK_CNT_W'(1);
        end
    end

    // ******************************
    // peripheral bus domains
    // ******************************
    for (genvar g = 0; g < NPB; g++)
    begin : g_pb
        assign pb_wr[g] = paddr == OFS_PBSEL0 + 8'(4 * g);
        always_ff @(posedge pclk or negedge srst_n)
        begin
            if (!srst_n)
            begin
                pb_div_q[g] <= DIV_RST;
                pb_clk_en_q[g] <= 1'b1;
            end
            else
            begin
                if (wr_en && ckrdy && pb_wr[g])
                    pb_div_q[g] <= pwdata[7:0];
                pb_clk_en_q[g] <= !(slp_d == PRM_SLEEP && mode_d >= SLP_STANDBY);
            end
        end
    end

    // ******************************
    // control and module clocks
    // ******************************
    always_ff @(posedge pclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            pll_en_q <= 2'h0;
            mgr_clk_en_q <= 1'b1;
            usb_reg_en_q <= 1'b1;
            mod_clk_en_q <= '1;
        end
        else
        begin
            if (wr_en && paddr == OFS_CTRL)
            begin
                pll_en_q <= pwdata[CTRL_PLL1:CTRL_PLL0];
                usb_reg_en_q <= pwdata[CTRL_USBREG];
                if (pwdata[CTRL_MGROFF])
                    mgr_clk_en_q <= 1'b0;
            end
            if (wr_en && paddr == OFS_CLKMASK)
                mod_clk_en_q <= pwdata[NMOD-1:0];
        end
    end

    // soft request lasts one edge into the reset it starts, so that edge records its cause
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            soft_q <= 1'b0;
        else
            soft_q <= srst_n && (wr_en && paddr == OFS_CTRL ? pwdata[CTRL_SOFT] : soft_q);
    end

    // ******************************
    // sleep and wake
    // ******************************
    always_comb
    begin
        slp_d = slp_q;
        mode_d = slp_mode_q;
        unique case (slp_q)
            PRM_RUN:
            begin
                if (sleep_req)
                begin
                    slp_d = PRM_SLEEP;
                    mode_d = sleep_mode;
                end
            end
            PRM_SLEEP:
            begin
                if (wake_irq)
                    slp_d = PRM_RUN;
            end
        endcase
    end

    // only an interrupt or a system reset leaves sleep; rc stays on below static mode
    always_ff @(posedge pclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            slp_q <= PRM_RUN;
            slp_mode_q <= 3'h0;
            cpu_clk_en_q <= 1'b1;
            hsb_clk_en_q <= 1'b1;
            osc_en_q <= 1'b1;
            rc_osc_en_q <= 1'b1;
        end
        else
        begin
            slp_q <= slp_d;
            slp_mode_q <= mode_d;
            cpu_clk_en_q <= slp_d == PRM_RUN;
            hsb_clk_en_q <= !(slp_d == PRM_SLEEP && mode_d >= SLP_FROZEN);
            osc_en_q <= !(slp_d == PRM_SLEEP && mode_d >= SLP_STOP);
            rc_osc_en_q <= !(slp_d == PRM_SLEEP && mode_d >= SLP_STATIC);
        end
    end

    // ******************************
    // boot fetch
    // ******************************
    always_ff @(posedge pclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            cpu_fetch_en_q <= 1'b0;
            boot_addr_q <= RESET_VEC;
        end
        else
        begin
            cpu_fetch_en_q <= 1'b1;
            boot_addr_q <= RESET_VEC;
        end
    end

    // ******************************
    // interrupt
    // ******************************
    assign ev[IRQ_CKRDY] = ck_rise;
    assign ev[IRQ_WAKE] = slp_q == PRM_SLEEP && wake_irq;

    // only bits actually returned are cleared, so a late event survives
    always_ff @(posedge pclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            isr_q <= '0;
            imr_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (rd_done && paddr == OFS_ISR)
                isr_q <= (isr_q & ~prdata_q[NIRQ-1:0]) | ev;
            else
                isr_q <= isr_q | ev;
            if (wr_en && paddr == OFS_IMR)
                imr_q <= pwdata[NIRQ-1:0];
            irq_q <= |(isr_q & imr_q);
        end
    end

    // ******************************
    // checks
    // ******************************
    sequence ck_wr_s;
        wr_en && ckrdy && paddr == OFS_PROCESSOR_CLOCK_SELECT;
    endsequence
    sequence ck_wait_s;
        !ckrdy [*5] ##1 ckrdy;
    endsequence

    ckrdy_seq_a: assert property (@(posedge pclk) disable iff (!srst_n)
        ck_wr_s |=> ck_wait_s)
        else $error("clock ready timing wrong");
    hsb_mirror_a: assert property (@(posedge pclk) disable iff (!srst_n)
        setup && !pwrite && paddr == OFS_FAST_BUS_CLOCK_SELECT |=> prdata_q == {24'h0, cpu_div_q}
            || !mgr_clk_en_q)
        else $error("fast bus select not mirroring cpu select");
    start_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(srst_n) |-> pll_en_q == 2'h0 && mod_clk_en_q == '1 && cpu_div_q == DIV_RST
            && main_clk_sel_q == MC_RC)
        else $error("start-up clock state wrong");
    mgr_off_a: assert property (@(posedge pclk) disable iff (!srst_n)
        !mgr_clk_en_q |=> !mgr_clk_en_q && !$past(wr_en))
        else $error("manager bus clock came back without reset");
    fetch_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(srst_n) |=> cpu_fetch_en_q && boot_addr_q == RESET_VEC)
        else $error("fetch not started at reset address");
    wake_a: assert property (@(posedge pclk) disable iff (!srst_n)
        slp_q == PRM_SLEEP && wake_irq |=> slp_q == PRM_RUN && cpu_clk_en_q
            && isr_q[IRQ_WAKE])
        else $error("wake did not restart cpu");
    irq_level_a: assert property (@(posedge pclk) disable iff (!srst_n)
        |(isr_q & imr_q) |=> irq_q)
        else $error("interrupt not raised");
    mon_fuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        loaded_q && !$past(loaded_q) |-> io_mon_en_q == $past(fuse_io_mon_keep)
            && core_mon_en_q == $past(fuse_core_mon_keep))
        else $error("monitor enables not taken from fuses");
    main_clock_source_select_ready_a: assert property (@(posedge pclk) disable iff (!srst_n)
        $changed(main_clk_sel_q) |-> |($past(src_ready) & (NSRC'(1) << main_clk_sel_q)))
        else $error("main clock moved to unready source");
endmodule : prm_top

// file: logic/prm_pkg.sv
// Purpose: shared constants for the power and clock manager
// Assumes: apb slave, 32-bit data, pclk at 50 MHz
// Notes: offsets are byte addresses, one aligned word each
package prm_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RC_TYP_HZ = 115000;
    localparam int CK_SETTLE_NS = 100;
    localparam int CK_SETTLE_CYC = (CK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CK_CNT_W = 3;
    localparam logic [CK_CNT_W-1:0] CK_LOAD = CK_CNT_W'(CK_SETTLE_CYC);
    localparam logic [31:0] RESET_VEC = 32'h8000_0000;
    // ******************************
    // register offsets
    // ******************************
    localparam logic [7:0] OFS_MAIN_CLOCK_SOURCE_SELECT = 8'h00;
    localparam logic [7:0] OFS_PROCESSOR_CLOCK_SELECT = 8'h04;
    localparam logic [7:0] OFS_FAST_BUS_CLOCK_SELECT = 8'h08;
    localparam logic [7:0] OFS_PBSEL0 = 8'h0c;
    localparam logic [7:0] OFS_CLKMASK = 8'h20;
    localparam logic [7:0] OFS_CTRL = 8'h24;
    localparam logic [7:0] OFS_SLEEP = 8'h28;
    localparam logic [7:0] OFS_RCAUSE = 8'h2c;
    localparam logic [7:0] OFS_ISR = 8'h30;
    localparam logic [7:0] OFS_IMR = 8'h34;
    localparam logic [7:0] OFS_SR = 8'h38;
    // ******************************
    // fields and reset values
    // ******************************
    localparam int MCW = 2;
    localparam logic [MCW-1:0] MC_RC = 2'h0;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam int CTRL_PLL0 = 0;
    localparam int CTRL_PLL1 = 1;
    localparam int CTRL_MGROFF = 2;
    localparam int CTRL_SOFT = 3;
    localparam int CTRL_USBREG = 4;
    localparam int NIRQ = 2;
    localparam int IRQ_CKRDY = 0;
    localparam int IRQ_WAKE = 1;
    localparam int NCAUSE = 6;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_BOD_IO = 1;
    localparam int CAUSE_BOD_CORE = 2;
    localparam int CAUSE_EXT = 3;
    localparam int CAUSE_WDT = 4;
    localparam int CAUSE_SOFT = 5;
    localparam logic [NCAUSE-1:0] CAUSE_POR_V = 6'h01;
    localparam logic [2:0] SLP_FROZEN = 3'h1;
    localparam logic [2:0] SLP_STANDBY = 3'h2;
    localparam logic [2:0] SLP_STOP = 3'h3;
    localparam logic [2:0] SLP_STATIC = 3'h5;
    typedef enum logic {PRM_RUN = 1'b0, PRM_SLEEP = 1'b1} prm_slp_e;
endpackage : prm_pkg

// file: logic/prm_rst_if.sv
// Purpose: reset sources and reset result between manager and reset control
// Assumes: all fields synchronous to pclk except the async reset path
// Notes: none
interface prm_rst_if;
    import prm_pkg::*;
    logic io_ok;
    logic core_ok;
    logic io_en;
    logic core_en;
    logic pin_n;
    logic soft_req;
    logic wdt_req;
    logic sys_rst_n;
    logic [NCAUSE-1:0] cause;
    modport ctl (input io_ok, core_ok, io_en, core_en, pin_n, soft_req, wdt_req,
        output sys_rst_n, cause);
    modport mgr (output io_ok, core_ok, io_en, core_en, pin_n, soft_req, wdt_req,
        input sys_rst_n, cause);
endinterface : prm_rst_if

// file: logic/prm_rst_ctl.sv
// Purpose: reset source gathering, synchronised release, cause record
// Assumes: presetn is the power-on reset
// Notes: cause survives every reset except power-on
module prm_rst_ctl
    import prm_pkg::*;
(
    input logic pclk,
    input logic presetn,
    prm_rst_if.ctl rif
);
    logic hold_n;
    logic s1_q;
    logic s2_q;
    logic in_rst_q;
    logic [NCAUSE-1:0] src;
    logic [NCAUSE-1:0] cause_q;

    assign src[CAUSE_POR] = 1'b0;
    assign src[CAUSE_BOD_IO] = rif.io_en && !rif.io_ok;
    assign src[CAUSE_BOD_CORE] = rif.core_en && !rif.core_ok;
    assign src[CAUSE_EXT] = !rif.pin_n;
    assign src[CAUSE_WDT] = rif.wdt_req;
    assign src[CAUSE_SOFT] = rif.soft_req;
    // any source pulls reset at once, no clock needed
    assign hold_n = presetn && !(|src);
    assign rif.sys_rst_n = s2_q;
    assign rif.cause = cause_q;

    // ******************************
    // release synchroniser
    // ******************************
    always_ff @(posedge pclk or negedge hold_n)
    begin
        if (!hold_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end
        else
        begin
            s1_q <= 1'b1;
            s2_q <= s1_q;
        end
    end

    // ******************************
    // cause record
    // ******************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cause_q <= CAUSE_POR_V;
            in_rst_q <= 1'b1;
        end
        else
        begin
            in_rst_q <= !s2_q;
            if (|src)
                cause_q <= in_rst_q ? (cause_q | src) : src;
        end
    end

    rel_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s2_q) |-> $past(s1_q))
        else $error("reset released without synchroniser stage");
    ext_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rif.pin_n |-> !s2_q ##1 cause_q[CAUSE_EXT])
        else $error("reset pin not seen as reset or cause");
    sup_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rif.io_en && !rif.io_ok) || (rif.core_en && !rif.core_ok) |-> !s2_q)
        else $error("reset released with bad supply");
endmodule : prm_rst_ctl

// file: tb/prm_board.sv
// Purpose: board logic that drives the active-low reset pin
// Assumes: supply_up is high once the input supply is above its threshold
// Notes: pin is driven at all times, so no pull level is modelled
module prm_board
(
    input logic supply_up,
    input logic ext_req,
    output logic reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // held low through power-up, covers boards with a slow supply ramp
    assign reset_pin_n = supply_up & ~ext_req;
endmodule : prm_board

// file: tb/test_power_up_reset_clock_startup.sv
// Purpose: self-checking bench for the power and clock manager start-up
// Assumes: apb answer taken at the rising edge, other outputs checked on the falling edge
// Notes: every wait is bounded; a spent bound counts as a mismatch
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, (e), (g)); end end
`define WAITV(s, v) for (int k = 0; k < 200 && (s) !== (v); k++) @(negedge pclk); \
    if ((s) !== (v)) begin n_errors++; test_done(); end
module test_power_up_reset_clock_startup
    import prm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, reset_pin_n;
    logic [7:0] paddr, cpu_div_q;
    logic [31:0] pwdata, prdata_q, rd, mod_clk_en_q, boot_addr_q;
    logic io_ok, core_ok, wdt_req, sleep_req, wake_irq, supply_up, ext_req, err;
    logic [3:0] src_ready;
    logic [2:0] sleep_mode;
    logic sys_rst_n_q, io_mon_en_q, core_mon_en_q, rc_osc_en_q, cpu_clk_en_q, hsb_clk_en_q;
    logic mgr_clk_en_q, usb_reg_en_q, cpu_fetch_en_q, irq_q, osc_en_q;
    logic [1:0] pll_en_q, pb_clk_en_q;
    logic [MCW-1:0] main_clk_sel_q;
    logic [1:0][7:0] pb_div_q;
    int n_errors = 0;
    int checks_done = 0;

    prm_board board (.supply_up, .ext_req, .reset_pin_n);
    prm_top #(.NPB(2), .NMOD(32), .NSRC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .reset_pin_n,
        .io_supply_monitor_ok(io_ok), .core_supply_monitor_ok(core_ok),
        .fuse_io_mon_keep(1'b1), .fuse_core_mon_keep(1'b0), .wdt_reset_req(wdt_req),
        .src_ready, .sleep_req, .sleep_mode, .wake_irq, .sys_rst_n_q, .io_mon_en_q,
        .core_mon_en_q, .rc_osc_en_q, .osc_en_q, .pll_en_q, .main_clk_sel_q, .cpu_div_q,
        .pb_div_q, .cpu_clk_en_q, .hsb_clk_en_q, .pb_clk_en_q, .mod_clk_en_q, .mgr_clk_en_q,
        .usb_reg_en_q, .cpu_fetch_en_q, .boot_addr_q, .irq_q);

    // ****************************************
    // bus tasks and closing
    // ****************************************
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // request held until the edge that samples pready high
        @(posedge pclk);
        while (pready_q !== 1'b1 && k < 50)
        begin
            @(posedge pclk);
            k++;
        end
        if (pready_q !== 1'b1)
        begin
            n_errors++;
            test_done();
        end
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask : rchk

    task automatic cause_chk(input int b, input string nm);
        `CHK("in_reset", 1'b0, sys_rst_n_q)
        `WAITV(sys_rst_n_q, 1'b1)
        repeat (2) @(negedge pclk);
        rchk(OFS_RCAUSE, 32'h1 << b, nm);
    endtask : cause_chk

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, io_ok, core_ok} = '0;
        {wdt_req, sleep_req, sleep_mode, wake_irq, supply_up, ext_req} = '0;
        src_ready = 4'h1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        supply_up <= 1'b1;
        repeat (3) @(posedge pclk);
        io_ok <= 1'b1;
        repeat (5) @(negedge pclk);
        `CHK("rst_held", 1'b0, sys_rst_n_q)
        `CHK("mon_on", 2'b11, {io_mon_en_q, core_mon_en_q})
        `CHK("pll_off", 2'b00, pll_en_q)
        `CHK("div_off", {DIV_RST, DIV_RST, DIV_RST}, {cpu_div_q, pb_div_q})
        `CHK("main_sel", MC_RC, main_clk_sel_q)
        `CHK("rc_on", 1'b1, rc_osc_en_q)
        `CHK("mgr_clk", 1'b1, mgr_clk_en_q)
        `CHK("no_fetch", 1'b0, cpu_fetch_en_q)
        @(posedge pclk);
        core_ok <= 1'b1;
        `WAITV(sys_rst_n_q, 1'b1)
        repeat (3) @(negedge pclk);
        `CHK("fetch", 1'b1, cpu_fetch_en_q)
        `CHK("boot", RESET_VEC, boot_addr_q)
        `CHK("mon_fuse", 2'b10, {io_mon_en_q, core_mon_en_q})
        `CHK("dom_on", 4'hf, {cpu_clk_en_q, hsb_clk_en_q, pb_clk_en_q})
        `CHK("mods_on", 32'hffff_ffff, mod_clk_en_q)
        apb(1'b0, OFS_RCAUSE, 32'h0);
        `CHK("cause_por", 1'b1, rd[CAUSE_POR])
        // core monitor switched off by fuse, so a sag must not reset
        @(posedge pclk);
        core_ok <= 1'b0;
        repeat (4) @(negedge pclk);
        `CHK("core_off", 1'b1, sys_rst_n_q)
        @(posedge pclk);
        core_ok <= 1'b1;
        apb(1'b1, OFS_IMR, 32'h1 << IRQ_CKRDY);
        apb(1'b1, OFS_PROCESSOR_CLOCK_SELECT, 32'h81);
        `WAITV(irq_q, 1'b1)
        `CHK("cpu_div", 8'h81, cpu_div_q)
        rchk(OFS_FAST_BUS_CLOCK_SELECT, 32'h81, "hsb_mirror");
        apb(1'b1, OFS_FAST_BUS_CLOCK_SELECT, 32'h03);
        rchk(OFS_FAST_BUS_CLOCK_SELECT, 32'h81, "hsb_ro");
        rchk(OFS_ISR, 32'h1 << IRQ_CKRDY, "isr_ckrdy");
        repeat (2) @(negedge pclk);
        `CHK("irq_clr", 1'b0, irq_q)
        apb(1'b1, OFS_IMR, 32'h0);
        apb(1'b1, OFS_PBSEL0, 32'h82);
        repeat (12) @(negedge pclk);
        `CHK("irq_masked", 1'b0, irq_q)
        `CHK("pb_div", 8'h82, pb_div_q[0])
        rchk(OFS_ISR, 32'h1 << IRQ_CKRDY, "isr_masked");
        apb(1'b1, OFS_MAIN_CLOCK_SOURCE_SELECT, 32'h1);
        `CHK("mc_refused", MC_RC, main_clk_sel_q)
        @(posedge pclk);
        src_ready <= 4'h3;
        apb(1'b1, OFS_MAIN_CLOCK_SOURCE_SELECT, 32'h1);
        `CHK("mc_taken", 2'h1, main_clk_sel_q)
        apb(1'b0, 8'hfc, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, OFS_CLKMASK, 32'h0000_00f0);
        `CHK("mask", 32'h0000_00f0, mod_clk_en_q)
        apb(1'b1, OFS_CTRL, 32'h0);
        `CHK("usb_reg", 1'b0, usb_reg_en_q)
        @(posedge pclk);
        sleep_req <= 1'b1;
        sleep_mode <= SLP_STANDBY;
        @(posedge pclk);
        sleep_req <= 1'b0;
        @(negedge pclk);
        `CHK("asleep", 4'b0001, {cpu_clk_en_q, hsb_clk_en_q, |pb_clk_en_q, osc_en_q})
        rchk(OFS_SLEEP, 32'(SLP_STANDBY), "slp_mode");
        rchk(OFS_SR, 32'h7, "status");
        @(posedge pclk);
        wake_irq <= 1'b1;
        @(posedge pclk);
        wake_irq <= 1'b0;
        `WAITV(cpu_clk_en_q, 1'b1)
        rchk(OFS_ISR, 32'h1 << IRQ_WAKE, "isr_wake");
        apb(1'b1, OFS_CTRL, 32'h1 << CTRL_MGROFF);
        `CHK("mgr_off", 1'b0, mgr_clk_en_q)
        apb(1'b1, OFS_CLKMASK, 32'hffff_ffff);
        `CHK("mask_locked", 32'h0000_00f0, mod_clk_en_q)
        @(posedge pclk);
        ext_req <= 1'b1;
        @(negedge pclk);
        `CHK("pin_async", 1'b0, sys_rst_n_q)
        repeat (3) @(posedge pclk);
        ext_req <= 1'b0;
        cause_chk(CAUSE_EXT, "cause_pin");
        `CHK("mgr_back", 1'b1, mgr_clk_en_q)
        `CHK("mask_back", 32'hffff_ffff, mod_clk_en_q)
        @(posedge pclk);
        wdt_req <= 1'b1;
        @(posedge pclk);
        wdt_req <= 1'b0;
        cause_chk(CAUSE_WDT, "cause_wdt");
        apb(1'b1, OFS_CTRL, 32'h1 << CTRL_SOFT);
        cause_chk(CAUSE_SOFT, "cause_soft");
        test_done();
    end
endmodule : test_power_up_reset_clock_startup
